/* File: verilog/pot_wiper_serial_target.sv */
// Two-wire serial target of a dual 256-position wiper, with logic outputs.
// Assumes scl_in/sda_in are raw pin levels, link_clk oversamples them
// several times per bus bit, and the pin pad builds the open-drain wire.
`timescale 1ns/1ps

// Functional notes
// [RULE_01] Address byte: fixed five bits, two straps, R/W
// [RULE_02] Selected only when strap bits match pins
// [RULE_03] Controller opens each transfer with start condition
// [RULE_04] Matching target acknowledges; others never drive
// [RULE_05] R/W one reads, zero writes
// [RULE_06] Writes carry instruction byte first; reads none
// [RULE_07] Instruction bit 7 selects wiper channel
// [RULE_08] Bit 6 moves selected wiper to centre
// [RULE_09] Bit 5 shuts selected channel down
// [RULE_10] Low shutdown pin shuts down like bit
// [RULE_11] Bits 4 and 3 drive logic outputs
// [RULE_12] Low three instruction bits are ignored
// [RULE_13] Third write frame loads selected wiper latch
// [RULE_14] Nine clocks per byte, MSB first, acknowledge
// [RULE_15] Data changes only while clock low
// [RULE_16] Read sends wiper byte right after address
// [RULE_17] Controller ends transfer with stop condition
// [RULE_18] Further write bytes keep updating selected wiper
// [RULE_19] New instruction needs a fresh start sequence
// [RULE_20] Repeated reads return wiper byte again
// [RULE_21] Read returns most recently selected channel
// [RULE_22] Instruction-only write then repeated start read
// [RULE_23] Power-on presets every wiper latch to midscale
// [RULE_24] Shutdown keeps latch contents for later reuse
// [RULE_25] Software shutdown ends at next new command
// [RULE_26] Logic outputs low after power-up
// [RULE_27] Midscale code is 0x80
module pot_wiper_serial_target
    import pot_wiper_pkg::*;
#(
    parameter logic [4:0] ADDR_FIXED = 5'h12  // Arbitrary neutral value
) (
    // Core clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Link sampling clock
    input  wire logic       link_clk,
    // Serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Straps and shutdown pin
    input  wire logic       addr_strap_0,
    input  wire logic       addr_strap_1,
    input  wire logic       shutdown_pin_n,
    // Wiper and logic outputs
    output logic [7:0]      wiper_channel_1,
    output logic [7:0]      wiper_channel_2,
    output logic            shutdown_1,
    output logic            shutdown_2,
    output logic            logic_out_1,
    output logic            logic_out_2
);

    ////////////////////////////////////////////////////////////////////////
    // Link and core domain state
    link_state_t ls_reg;
    link_state_t ls_next;
    core_state_t cs_reg;
    core_state_t cs_next;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_end;
    logic       addr_match;
    logic [7:0] cur_wiper;

    // Bus events from synchronised pins; first stages are never read here
    assign scl_rise   = ls_reg.scl_s2 & ~ls_reg.scl_d;
    assign scl_fall   = ~ls_reg.scl_s2 & ls_reg.scl_d;
    assign start_det  = ls_reg.scl_s2 & ls_reg.scl_d & ls_reg.sda_d & ~ls_reg.sda_s2;
    assign stop_det   = ls_reg.scl_s2 & ls_reg.scl_d & ~ls_reg.sda_d & ls_reg.sda_s2;
    assign byte_end   = scl_fall & (ls_reg.cnt == BYTE_BITS);
    // Fixed code, then straps as seen on the pins
    assign addr_match = (ls_reg.shreg[7:3] == ADDR_FIXED)            // [RULE_01]
                      & (ls_reg.shreg[ADDR_STRAP1_BIT] == ls_reg.st1_s2)
                      & (ls_reg.shreg[ADDR_STRAP0_BIT] == ls_reg.st0_s2); // [RULE_02]
    // Readback follows the last channel chosen by an instruction
    assign cur_wiper  = ls_reg.chan ? ls_reg.wip2 : ls_reg.wip1;    // [RULE_21]

    ////////////////////////////////////////////////////////////////////////
    // Link protocol engine: bits sampled on SCL rise, SDA moved on SCL fall
    always_comb begin
        ls_next        = ls_reg;
        ls_next.scl_s1 = scl_in;
        ls_next.scl_s2 = ls_reg.scl_s1;
        ls_next.scl_d  = ls_reg.scl_s2;
        ls_next.sda_s1 = sda_in;
        ls_next.sda_s2 = ls_reg.sda_s1;
        ls_next.sda_d  = ls_reg.sda_s2;
        ls_next.st0_s1 = addr_strap_0;
        ls_next.st0_s2 = ls_reg.st0_s1;
        ls_next.st1_s1 = addr_strap_1;
        ls_next.st1_s2 = ls_reg.st1_s1;
        ls_next.sda_out = 1'b0;
        if (start_det) begin
            // Start or repeated start always restarts address capture
            ls_next.st       = L_ADDR;                              // [RULE_22]
            ls_next.cnt      = 4'h0;
            ls_next.sda_oe_n = 1'b1;
        end else if (stop_det) begin
            ls_next.st       = L_IDLE;
            ls_next.sda_oe_n = 1'b1;
        end else begin
            case (ls_reg.st)
                L_ADDR, L_INSTR, L_WDATA: begin
                    // Eight bits MSB first, then the acknowledge slot
                    if (scl_rise) begin                             // [RULE_14]
                        ls_next.shreg = {ls_reg.shreg[6:0], ls_reg.sda_s2};
                        ls_next.cnt   = ls_reg.cnt + 4'h1;
                    end
                    if (byte_end) begin
                        ls_next.sda_oe_n = 1'b0;
                        if (ls_reg.st == L_ADDR) begin
                            if (addr_match) begin
                                ls_next.rw = ls_reg.shreg[ADDR_RW_BIT]; // [RULE_05]
                                ls_next.st = L_AACK;                // [RULE_04]
                            end else begin
                                ls_next.sda_oe_n = 1'b1;
                                ls_next.st       = L_WAIT;          // [RULE_02]
                            end
                        end else if (ls_reg.st == L_INSTR) begin
                            // Bits 2..0 are never looked at
                            ls_next.chan = ls_reg.shreg[INSTR_CHAN_BIT]; // [RULE_07] [RULE_12]
                            if (ls_reg.shreg[INSTR_MID_BIT]) begin  // [RULE_08]
                                if (ls_reg.shreg[INSTR_CHAN_BIT]) begin
                                    ls_next.wip2 = MIDSCALE_CODE;   // [RULE_27]
                                end else begin
                                    ls_next.wip1 = MIDSCALE_CODE;
                                end
                            end
                            // A new command clears any earlier software shutdown
                            ls_next.sd1 = ~ls_reg.shreg[INSTR_CHAN_BIT]
                                        & ls_reg.shreg[INSTR_SD_BIT];   // [RULE_09] [RULE_25]
                            ls_next.sd2 = ls_reg.shreg[INSTR_CHAN_BIT]
                                        & ls_reg.shreg[INSTR_SD_BIT];
                            ls_next.o2  = ls_reg.shreg[INSTR_OUT2_BIT]; // [RULE_11]
                            ls_next.o1  = ls_reg.shreg[INSTR_OUT1_BIT];
                            ls_next.upd_tgl = ~ls_reg.upd_tgl;
                            ls_next.st  = L_IACK;
                        end else begin
                            // Each data byte reloads the selected latch
                            if (ls_reg.chan) begin                  // [RULE_13] [RULE_18]
                                ls_next.wip2 = ls_reg.shreg;
                            end else begin
                                ls_next.wip1 = ls_reg.shreg;
                            end
                            ls_next.upd_tgl = ~ls_reg.upd_tgl;
                            ls_next.st      = L_DACK;
                        end
                    end
                end
                L_AACK: begin
                    if (scl_fall) begin
                        ls_next.cnt = 4'h0;
                        if (ls_reg.rw) begin
                            // Read: no instruction, wiper byte follows at once
                            ls_next.shreg    = cur_wiper;           // [RULE_16] [RULE_06]
                            ls_next.sda_oe_n = cur_wiper[7];
                            ls_next.st       = L_READ;
                        end else begin
                            ls_next.sda_oe_n = 1'b1;
                            ls_next.st       = L_INSTR;             // [RULE_06]
                        end
                    end
                end
                L_IACK, L_DACK: begin
                    if (scl_fall) begin
                        ls_next.sda_oe_n = 1'b1;
                        ls_next.cnt      = 4'h0;
                        ls_next.st       = L_WDATA;                 // [RULE_18]
                    end
                end
                L_READ: begin
                    if (scl_rise) begin
                        ls_next.cnt = ls_reg.cnt + 4'h1;
                    end
                    // Only moves SDA on the falling clock edge
                    if (byte_end) begin                             // [RULE_15]
                        ls_next.sda_oe_n = 1'b1;
                        ls_next.st       = L_RACK;
                    end else if (scl_fall) begin
                        ls_next.shreg    = {ls_reg.shreg[6:0], 1'b0};
                        ls_next.sda_oe_n = ls_reg.shreg[6];
                    end
                end
                L_RACK: begin
                    // Controller NACK ends the read; ACK asks for another byte
                    if (scl_rise) begin
                        ls_next.st = ls_reg.sda_s2 ? L_WAIT : L_RNEXT;
                    end
                end
                L_RNEXT: begin
                    if (scl_fall) begin
                        ls_next.shreg    = cur_wiper;               // [RULE_20]
                        ls_next.sda_oe_n = cur_wiper[7];
                        ls_next.cnt      = 4'h0;
                        ls_next.st       = L_READ;
                    end
                end
                default: begin
                    // Idle or not addressed: wait for the next start
                    ls_next.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // Link registers; latches come up at midscale
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            ls_reg          <= '0;
            ls_reg.st       <= L_IDLE;
            ls_reg.wip1     <= WIPER_RESET;                         // [RULE_23]
            ls_reg.wip2     <= WIPER_RESET;
            ls_reg.o1       <= LOGIC_OUT_RESET;                     // [RULE_26]
            ls_reg.o2       <= LOGIC_OUT_RESET;
            ls_reg.sda_oe_n <= 1'b1;
            ls_reg.scl_s1   <= 1'b1;
            ls_reg.scl_s2   <= 1'b1;
            ls_reg.scl_d    <= 1'b1;
            ls_reg.sda_s1   <= 1'b1;
            ls_reg.sda_s2   <= 1'b1;
            ls_reg.sda_d    <= 1'b1;
        end else begin
            ls_reg <= ls_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: toggle crossing, data held stable for a whole bus byte
    always_comb begin
        cs_next         = cs_reg;
        cs_next.tgl_s1  = ls_reg.upd_tgl;
        cs_next.tgl_s2  = cs_reg.tgl_s1;
        cs_next.tgl_s3  = cs_reg.tgl_s2;
        cs_next.shutdown_pin_n_s1 = shutdown_pin_n;
        cs_next.shutdown_pin_n_s2 = cs_reg.shutdown_pin_n_s1;
        if (cs_reg.tgl_s2 != cs_reg.tgl_s3) begin
            cs_next.wip1 = ls_reg.wip1;
            cs_next.wip2 = ls_reg.wip2;
            cs_next.sd1  = ls_reg.sd1;
            cs_next.sd2  = ls_reg.sd2;
            cs_next.o1   = ls_reg.o1;
            cs_next.o2   = ls_reg.o2;
        end
        // Latch codes stay put; shutdown only parks the wiper
        cs_next.shut1 = cs_next.sd1 | ~cs_reg.shutdown_pin_n_s2;              // [RULE_10] [RULE_24]
        cs_next.shut2 = cs_next.sd2 | ~cs_reg.shutdown_pin_n_s2;
    end

    // Core registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_reg         <= '0;
            cs_reg.shutdown_pin_n_s1 <= 1'b1;
            cs_reg.shutdown_pin_n_s2 <= 1'b1;
            cs_reg.wip1    <= WIPER_RESET;                          // [RULE_23]
            cs_reg.wip2    <= WIPER_RESET;
            cs_reg.o1      <= LOGIC_OUT_RESET;                      // [RULE_26]
            cs_reg.o2      <= LOGIC_OUT_RESET;
        end else begin
            cs_reg <= cs_next;
        end
    end

    // Outputs straight from flip-flops
    assign sda_out         = ls_reg.sda_out;
    assign sda_oe_n        = ls_reg.sda_oe_n;
    assign wiper_channel_1 = cs_reg.wip1;
    assign wiper_channel_2 = cs_reg.wip2;
    assign shutdown_1      = cs_reg.shut1;
    assign shutdown_2      = cs_reg.shut2;
    assign logic_out_1     = cs_reg.o1;
    assign logic_out_2     = cs_reg.o2;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_addr_accept: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_01]
        (ls_reg.st == L_ADDR && byte_end && !start_det && !stop_det && addr_match)
        |=> (ls_reg.st == L_AACK && !ls_reg.sda_oe_n))
        else $error("matching address not acknowledged");

    a_strap_reject: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_02]
        (ls_reg.st == L_ADDR && byte_end && !start_det && !stop_det && !addr_match)
        |=> (ls_reg.st == L_WAIT && ls_reg.sda_oe_n))
        else $error("mismatched address was not ignored");

    a_idle_silent: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_04]
        (ls_reg.st == L_WAIT || ls_reg.st == L_IDLE || ls_reg.st == L_INSTR)
        |-> ls_reg.sda_oe_n)
        else $error("target drives SDA while it should be silent");

    a_midscale_load: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_08]
        (ls_reg.st == L_INSTR && byte_end && !start_det && !stop_det
         && ls_reg.shreg[INSTR_MID_BIT] && !ls_reg.shreg[INSTR_CHAN_BIT])
        |=> ls_reg.wip1 == 8'h80)
        else $error("midscale reset did not load centre code");

    a_logic_out_set: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_11]
        (ls_reg.st == L_INSTR && byte_end && !start_det && !stop_det)
        |=> (ls_reg.o1 == $past(ls_reg.shreg[3]) && ls_reg.o2 == $past(ls_reg.shreg[4])))
        else $error("logic outputs do not follow instruction");

    a_write_load: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_13]
        (ls_reg.st == L_WDATA && byte_end && !start_det && !stop_det && ls_reg.chan)
        |=> ls_reg.wip2 == $past(ls_reg.shreg))
        else $error("data byte not loaded into selected latch");

    a_read_first: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_16]
        (ls_reg.st == L_AACK && scl_fall && ls_reg.rw && !start_det && !stop_det)
        |=> (ls_reg.st == L_READ && ls_reg.sda_oe_n == $past(cur_wiper[7])))
        else $error("read does not start with wiper MSB");

    a_sd_restore: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_25]
        (ls_reg.st == L_INSTR && byte_end && !start_det && !stop_det
         && !ls_reg.shreg[INSTR_SD_BIT])
        |=> (!ls_reg.sd1 && !ls_reg.sd2))
        else $error("software shutdown survives a new command");

    a_pin_shutdown: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_10]
        !cs_reg.shutdown_pin_n_s2 |=> (shutdown_1 && shutdown_2))
        else $error("shutdown pin low did not shut channels down");

    // Drive may only move just after a falling bus clock, or on start and stop
    a_sda_steady: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_15]
        (!scl_fall && !start_det && !stop_det) |=> $stable(ls_reg.sda_oe_n))
        else $error("target moved SDA away from a falling clock edge");

    a_ch1_load: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_18]
        (ls_reg.st == L_WDATA && byte_end && !start_det && !stop_det && !ls_reg.chan)
        |=> ls_reg.wip1 == $past(ls_reg.shreg))
        else $error("data byte not loaded into channel 1 latch");

endmodule

/* File: common/pot_wiper_pkg.sv */
// Shared constants and types for the two-wire wiper target.
// Assumes one potentiometer target per bus address, 8-bit wiper codes.
package pot_wiper_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Address byte layout
    localparam int         ADDR_RW_BIT      = 0;
    localparam int         ADDR_STRAP0_BIT  = 1;
    localparam int         ADDR_STRAP1_BIT  = 2;
    localparam logic [3:0] BYTE_BITS        = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Instruction byte layout, bits 2..0 are don't care
    localparam int         INSTR_CHAN_BIT   = 7;
    localparam int         INSTR_MID_BIT    = 6;
    localparam int         INSTR_SD_BIT     = 5;
    localparam int         INSTR_OUT2_BIT   = 4;
    localparam int         INSTR_OUT1_BIT   = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] MIDSCALE_CODE    = 8'h80;
    localparam logic [7:0] WIPER_RESET      = MIDSCALE_CODE;
    localparam logic       LOGIC_OUT_RESET  = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Link-side protocol states
    typedef enum logic [3:0] {
        L_IDLE  = 4'b0000,
        L_ADDR  = 4'b0001,
        L_AACK  = 4'b0010,
        L_INSTR = 4'b0011,
        L_IACK  = 4'b0100,
        L_WDATA = 4'b0101,
        L_DACK  = 4'b0110,
        L_READ  = 4'b0111,
        L_RACK  = 4'b1000,
        L_RNEXT = 4'b1001,
        L_WAIT  = 4'b1010
    } link_fsm_t;

    // All state clocked by the link clock
    typedef struct packed {
        link_fsm_t  st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic       rw;
        logic       chan;
        logic [7:0] wip1;
        logic [7:0] wip2;
        logic       sd1;
        logic       sd2;
        logic       o1;
        logic       o2;
        logic       upd_tgl;
        logic       sda_out;
        logic       sda_oe_n;
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_d;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_d;
        logic       st0_s1;
        logic       st0_s2;
        logic       st1_s1;
        logic       st1_s2;
    } link_state_t;

    // All state clocked by ref_clk
    typedef struct packed {
        logic       tgl_s1;
        logic       tgl_s2;
        logic       tgl_s3;
        logic       shutdown_pin_n_s1;
        logic       shutdown_pin_n_s2;
        logic [7:0] wip1;
        logic [7:0] wip2;
        logic       sd1;
        logic       sd2;
        logic       o1;
        logic       o2;
        logic       shut1;
        logic       shut2;
    } core_state_t;

endpackage

/* File: sim/i2c_ctrl_model.sv */
// Bit-banged two-wire bus controller for the wiper target.
// Assumes a pull-up on the data wire; paced by the core clock.
`timescale 1ns/1ps

module i2c_ctrl_model #(
    parameter int QTR = 10  // Core cycles per quarter bit
) (
    // Pacing clock
    input  wire logic clk,
    // Resolved data wire
    input  wire logic sda_wire,
    // Driven bus lines
    output logic      scl,
    output logic      sda_pull
);
    // Bus idles with both lines released high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tick();
        repeat (QTR) @(posedge clk);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_pull <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_pull <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask

    // Low first, so a read NACK still gives a rising data edge
    task automatic stop();
        sda_pull <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_pull <= 1'b0;
        tick();
    endtask

    // One clock pulse; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic v);
        sda_pull <= !b;
        tick();
        scl <= 1'b1;
        tick();
        v = sda_wire;
        tick();
        scl <= 1'b0;
        tick();
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], v);
        end
        bit_io(1'b1, v);
        ack = !v;
    endtask

    task automatic read_byte(input logic more, output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v);
            d[i] = v;
        end
        bit_io(!more, v);
    endtask
endmodule

/* File: sim/pot_wiper_serial_target_test.sv */
// Self-checking bench for the two-wire wiper target.
// Assumes the controller model in i2c_ctrl_model and a pulled-up data wire.
`timescale 1ns/1ps

module pot_wiper_serial_target_test;
    import pot_wiper_pkg::*;
    localparam logic [4:0] ADDR_FIXED = 5'h15; // Arbitrary value
    localparam int         LIMIT      = 40000;

    logic       ref_clk, link_clk, rst_n, addr_strap_0, addr_strap_1, shutdown_pin_n;
    logic       scl, sda_pull, sda_wire, sda_out, sda_oe_n, ack;
    logic [7:0] wiper_channel_1, wiper_channel_2, rdat;
    logic       shutdown_1, shutdown_2, logic_out_1, logic_out_2;
    int         fails, checked, cycles;

    // Open-drain wire: low whenever either party pulls
    assign sda_wire = !sda_pull && (sda_oe_n || sda_out);

    // Clocks; the link clock starts off-phase so edges drift apart
    always #10 ref_clk = !ref_clk;
    initial begin
        ref_clk = 1'b0;
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = !link_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    i2c_ctrl_model u_ctrl (.clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

    pot_wiper_serial_target #(.ADDR_FIXED(ADDR_FIXED)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_strap_0(addr_strap_0), .addr_strap_1(addr_strap_1),
        .shutdown_pin_n(shutdown_pin_n),
        .wiper_channel_1(wiper_channel_1), .wiper_channel_2(wiper_channel_2),
        .shutdown_1(shutdown_1), .shutdown_2(shutdown_2),
        .logic_out_1(logic_out_1), .logic_out_2(logic_out_2));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Address byte: fixed code, strap pair, read flag
    function automatic logic [7:0] addr_byte(input logic [1:0] strap, input logic rd);
        return {ADDR_FIXED, strap, rd};
    endfunction

    // Write without stop, so a repeated start may follow; n data bytes, top byte first
    task automatic wr(input logic [1:0] strap, input logic [7:0] instr, input int n,
                      input logic [15:0] data, input logic exp_ack);
        logic [15:0] d;
        d = data;
        u_ctrl.start();
        u_ctrl.write_byte(addr_byte(strap, 1'b0), ack);
        check("addr ack", {7'h00, ack}, {7'h00, exp_ack});
        u_ctrl.write_byte(instr, ack);
        check("instr ack", {7'h00, ack}, {7'h00, exp_ack});
        for (int i = 0; i < n; i++) begin
            u_ctrl.write_byte(d[15:8], ack);
            check("data ack", {7'h00, ack}, {7'h00, exp_ack});
            d = {d[7:0], 8'h00};
        end
    endtask

    // Stop, then let the crossing into the core domain settle
    task automatic done();
        u_ctrl.stop();
        repeat (20) @(posedge ref_clk);
    endtask

    task automatic rd(input int n, input logic [7:0] exp);
        u_ctrl.start();
        u_ctrl.write_byte(addr_byte(2'b01, 1'b1), ack);
        check("read ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            u_ctrl.read_byte(i < n - 1, rdat);
            check("read data", rdat, exp);
        end
        done();
    endtask

    // Compare all core-side outputs; pairs are {channel 2, channel 1}
    task automatic outs(input logic [7:0] w1, input logic [7:0] w2,
                        input logic [1:0] sd, input logic [1:0] lo);
        check("wiper 1", wiper_channel_1, w1);
        check("wiper 2", wiper_channel_2, w2);
        check("shutdown", {6'h00, shutdown_2, shutdown_1}, {6'h00, sd});
        check("logic outs", {6'h00, logic_out_2, logic_out_1}, {6'h00, lo});
        check("sda idle", {6'h00, sda_oe_n, sda_out}, 8'h02);
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            $display("MISMATCH timeout expected finish seen hang");
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        addr_strap_0 = 1'b1;
        addr_strap_1 = 1'b0;
        shutdown_pin_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        outs(8'h80, 8'h80, 2'b00, 2'b00);
        wr(2'b01, 8'h00, 1, 16'h3C00, 1'b1);
        done();
        wr(2'b01, 8'h80, 2, 16'h11A5, 1'b1);
        done();
        outs(8'h3C, 8'hA5, 2'b00, 2'b00);
        wr(2'b10, 8'h9F, 1, 16'h0000, 1'b0);
        done();
        outs(8'h3C, 8'hA5, 2'b00, 2'b00);
        wr(2'b01, 8'h9F, 0, 16'h0000, 1'b1);
        rd(3, 8'hA5);
        outs(8'h3C, 8'hA5, 2'b00, 2'b11);
        wr(2'b01, 8'h40, 0, 16'h0000, 1'b1);
        done();
        outs(8'h80, 8'hA5, 2'b00, 2'b00);
        rd(1, 8'h80);
        wr(2'b01, 8'hA0, 0, 16'h0000, 1'b1);
        done();
        outs(8'h80, 8'hA5, 2'b10, 2'b00);
        wr(2'b01, 8'h80, 0, 16'h0000, 1'b1);
        done();
        outs(8'h80, 8'hA5, 2'b00, 2'b00);
        shutdown_pin_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        outs(8'h80, 8'hA5, 2'b11, 2'b00);
        shutdown_pin_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        outs(8'h80, 8'hA5, 2'b00, 2'b00);
        // Channel 1 software shutdown, then channel 2 midscale with first output only
        wr(2'b01, 8'h20, 0, 16'h0000, 1'b1);
        done();
        outs(8'h80, 8'hA5, 2'b01, 2'b00);
        wr(2'b01, 8'hC8, 0, 16'h0000, 1'b1);
        done();
        outs(8'h80, 8'h80, 2'b00, 2'b01);
        finish_test();
    end
endmodule
